// file: hdl/memctl_pins_defines.vh
`ifndef MEMCTL_PINS_DEFINES_VH
`define MEMCTL_PINS_DEFINES_VH

// machine selection codes per chip select
`define MACH_CS 2'h0
`define MACH_SDRAM 2'h1
`define MACH_PROG 2'h2

// transaction size codes (bytes = 1, 2, 4, 8)
`define SIZE_1 2'h0
`define SIZE_2 2'h1
`define SIZE_4 2'h2
`define SIZE_8 2'h3

// port width codes
`define PORT_8 2'h0
`define PORT_16 2'h1
`define PORT_32 2'h2
`define PORT_64 2'h3

// buffer control modes
`define BCTL_RW_EN 1'h0
`define BCTL_EN_DIR 1'h1

// chip-select and sdram machine strobe timing, cycles
`define CS_SETUP_CYC 4'h1
`define SD_ACT_CYC 4'h2
`define SD_CAS_CYC 4'h2

// sdram command encodings {row_strobe, col_strobe, write_en}, active low
`define SD_CMD_NOP 3'h7
`define SD_CMD_ACT 3'h3
`define SD_CMD_READ 3'h5
`define SD_CMD_WRITE 3'h4

`endif

// file: hdl/lane_decode.v
`timescale 1ns/10ps
`include "memctl_pins_defines.vh"

// ==========================================
// byte lane decode from address, size and port width
module lane_decode (
   input wire [2:0] addr_lsb, // low address bits of the transaction
   input wire [1:0] size, // transaction size code
   input wire [1:0] port_width, // accessed port width code
   output reg [7:0] lanes // active-high lanes that take part
);
   reg [7:0] span;
   reg [2:0] off;

   // lanes are placed by the offset inside the port; narrow ports keep only their low lanes
   always @* begin
      span = 8'h00;
      off = 3'h0;
      case (size)
         `SIZE_1: span = 8'h01;
         `SIZE_2: span = 8'h03;
         `SIZE_4: span = 8'h0f;
         default: span = 8'hff;
      endcase
      case (port_width)
         `PORT_8: off = 3'h0;
         `PORT_16: off = {2'h0, addr_lsb[0]};
         `PORT_32: off = {1'h0, addr_lsb[1:0]};
         default: off = addr_lsb;
      endcase
      lanes = span << off;
      case (port_width)
         `PORT_8: lanes = lanes & 8'h01;
         `PORT_16: lanes = lanes & 8'h03;
         `PORT_32: lanes = lanes & 8'h0f;
         default: lanes = lanes;
      endcase
   end
endmodule

// file: hdl/memctl_pins.v
`timescale 1ns/10ps
`include "memctl_pins_defines.vh"

// Overview of operation
// - eight chip selects, one per device
// - paired buffer controls, mode from config field
// - drive burst address bits 27 and 28
// - address latch enable in external master mode
// - chip-select machine per-lane write enables
// - sdram machine drives eight data masks
// - programmable byte selects from address, size, width
// - address 10 row bit, then command bit
// - six program-driven general purpose lines
// - sdram write, row and column strobes
// - output enable during chip-select machine reads
// - transfer acknowledge terminates chip-select access
// - wait input stalls programmable machine sequence
// - parity byte select during parity accesses
// - sdram address mux control in external master
module memctl_pins #(
   parameter PROG_LEN = 4 // words in the programmable machine pattern
) (
   input wire clk, // system clock
   input wire rst, // asynchronous reset, active high
   input wire req, // access request pulse
   input wire [2:0] req_cs, // chip select index of the access
   input wire req_write, // 1 = write, 0 = read
   input wire [2:0] req_addr_lsb, // low address bits
   input wire [1:0] req_addr_burst, // burst address bits 27..28
   input wire sdram_addr10, // row address bit 10 from the address path
   input wire [1:0] req_size, // transaction size code
   input wire req_parity, // access involves parity storage
   input wire [15:0] cs_machine, // two-bit machine code per chip select
   input wire [15:0] cs_port_width, // two-bit port width per chip select
   input wire ext_master, // external master bus configuration
   input wire buffer_ctrl_config_field, // buffer control mode
   input wire [6*PROG_LEN-1:0] prog_gp_pattern, // gp line values per step
   input wire chipsel_transfer_ack_n, // transfer acknowledge, active low
   input wire prog_machine_wait, // wait, high stalls programmable machine
   output reg busy, // access in progress
   output reg done, // one-cycle pulse at access end
   output reg [7:0] chip_sel_n_r, // chip selects, active low
   output reg buffer_ctrl_a, // buffer control a
   output reg buffer_ctrl_b, // buffer control b
   output reg [1:0] burst_addr_bits, // burst address bits 27..28
   output reg addr_latch_en, // address latch enable
   output reg [7:0] lane_write_en_n, // per-lane write enables, active low
   output reg [7:0] sdram_data_mask, // sdram masks, high masks lane
   output reg [7:0] prog_machine_byte_sel_n, // byte selects, active low
   output reg sdram_addr10_cmd, // sdram address 10
   output reg [5:0] prog_gp_line, // general purpose lines 0..5
   output reg sdram_write_en_n, // sdram write enable, active low
   output reg sdram_row_strobe_n, // sdram row strobe, active low
   output reg sdram_col_strobe_n, // sdram column strobe, active low
   output reg mem_output_en_n, // memory output enable, active low
   output reg parity_byte_sel_n, // parity byte select, active low
   output reg sdram_addr_mux_ctrl // sdram address mux control
);
   // ==========================================
   // state machine
   localparam ST_IDLE = 3'h0;
   localparam ST_CS = 3'h1;
   localparam ST_SD_ACT = 3'h2;
   localparam ST_SD_CAS = 3'h3;
   localparam ST_PROG = 3'h4;
   localparam ST_END = 3'h5;

   reg [2:0] state_r;
   reg [3:0] cnt_r;
   reg [7:0] step_r;
   reg write_r;
   reg [1:0] mach_r;
   reg [7:0] lanes_r;
   wire [7:0] lanes;

   // machine code of a chip select, used for both request and held access
   function [1:0] mach_of;
      input [15:0] tab;
      input [2:0] idx;
      begin
         mach_of = tab[idx*2 +: 2];
      end
   endfunction

   lane_decode u_lane (
      .addr_lsb(req_addr_lsb),
      .size(req_size),
      .port_width(cs_port_width[req_cs*2 +: 2]),
      .lanes(lanes)
   );

   // ==========================================
   // access sequencing; every strobe is registered so pins come straight from flops
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         step_r <= 8'h00;
         write_r <= 1'h0;
         mach_r <= 2'h0;
         lanes_r <= 8'h00;
         busy <= 1'h0;
         done <= 1'h0;
         chip_sel_n_r <= 8'hff;
         buffer_ctrl_a <= 1'h1;
         buffer_ctrl_b <= 1'h1;
         burst_addr_bits <= 2'h0;
         addr_latch_en <= 1'h0;
         lane_write_en_n <= 8'hff;
         sdram_data_mask <= 8'hff;
         prog_machine_byte_sel_n <= 8'hff;
         sdram_addr10_cmd <= 1'h0;
         prog_gp_line <= 6'h3f;
         sdram_write_en_n <= 1'h1;
         sdram_row_strobe_n <= 1'h1;
         sdram_col_strobe_n <= 1'h1;
         mem_output_en_n <= 1'h1;
         parity_byte_sel_n <= 1'h1;
         sdram_addr_mux_ctrl <= 1'h0;
      end else begin
         done <= 1'h0;
         addr_latch_en <= 1'h0;
         case (state_r)
            ST_IDLE: begin
               if (req) begin
                  busy <= 1'h1;
                  write_r <= req_write;
                  lanes_r <= lanes;
                  mach_r <= mach_of(cs_machine, req_cs);
                  cnt_r <= 4'h0;
                  step_r <= 8'h00;
                  chip_sel_n_r <= ~(8'h01 << req_cs);
                  burst_addr_bits <= req_addr_burst;
                  addr_latch_en <= ext_master;
                  parity_byte_sel_n <= ~req_parity;
                  // enable/direction mode: a enables, b gives direction
                  if (buffer_ctrl_config_field == `BCTL_EN_DIR) begin
                     buffer_ctrl_a <= 1'h0;
                     buffer_ctrl_b <= ~req_write;
                  end else begin
                     buffer_ctrl_a <= req_write;
                     buffer_ctrl_b <= ~req_write;
                  end
                  case (mach_of(cs_machine, req_cs))
                     `MACH_SDRAM: begin
                        state_r <= ST_SD_ACT;
                        sdram_row_strobe_n <= 1'h0;
                        sdram_addr10_cmd <= sdram_addr10;
                        sdram_addr_mux_ctrl <= 1'h0;
                     end
                     `MACH_PROG: begin
                        state_r <= ST_PROG;
                        prog_machine_byte_sel_n <= ~lanes;
                        prog_gp_line <= prog_gp_pattern[5:0];
                     end
                     default: begin
                        state_r <= ST_CS;
                        if (req_write) begin
                           lane_write_en_n <= ~lanes;
                        end else begin
                           mem_output_en_n <= 1'h0;
                        end
                     end
                  endcase
               end
            end
            ST_CS: begin
               // acknowledge only counts after setup so a stale low cannot cut the cycle
               if (cnt_r >= `CS_SETUP_CYC && !chipsel_transfer_ack_n) begin
                  state_r <= ST_END;
               end else if (cnt_r < `CS_SETUP_CYC) begin
                  cnt_r <= cnt_r + 4'h1;
               end
            end
            ST_SD_ACT: begin
               sdram_row_strobe_n <= 1'h1;
               if (cnt_r + 4'h1 >= `SD_ACT_CYC) begin
                  state_r <= ST_SD_CAS;
                  cnt_r <= 4'h0;
                  sdram_col_strobe_n <= 1'h0;
                  sdram_write_en_n <= ~write_r;
                  sdram_addr10_cmd <= 1'h1; // auto precharge
                  sdram_addr_mux_ctrl <= ext_master; // column phase
                  sdram_data_mask <= ~lanes_r;
               end else begin
                  cnt_r <= cnt_r + 4'h1;
               end
            end
            ST_SD_CAS: begin
               sdram_col_strobe_n <= 1'h1;
               sdram_write_en_n <= 1'h1;
               if (cnt_r + 4'h1 >= `SD_CAS_CYC) begin
                  state_r <= ST_END;
               end else begin
                  cnt_r <= cnt_r + 4'h1;
               end
            end
            ST_PROG: begin
               // held high wait freezes the step and the gp lines
               if (!prog_machine_wait) begin
                  if (step_r + 8'h01 >= PROG_LEN[7:0]) begin
                     state_r <= ST_END;
                  end else begin
                     step_r <= step_r + 8'h01;
                     prog_gp_line <= prog_gp_pattern[(step_r + 8'h01)*6 +: 6];
                  end
               end
            end
            ST_END: begin
               state_r <= ST_IDLE;
               busy <= 1'h0;
               done <= 1'h1;
               chip_sel_n_r <= 8'hff;
               lane_write_en_n <= 8'hff;
               mem_output_en_n <= 1'h1;
               sdram_data_mask <= 8'hff;
               prog_machine_byte_sel_n <= 8'hff;
               prog_gp_line <= 6'h3f;
               parity_byte_sel_n <= 1'h1;
               sdram_addr_mux_ctrl <= 1'h0;
               buffer_ctrl_a <= 1'h1;
               buffer_ctrl_b <= 1'h1;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule

// file: tb/memctl_pins_chk.sv
`timescale 1ns/10ps
// ==========================================
// pin relation checks for the memory controller
module memctl_pins_chk (
   input wire clk, // system clock
   input wire rst, // asynchronous reset
   input wire busy, // access in progress
   input wire done, // end pulse
   input wire ext_master, // external master mode
   input wire chipsel_transfer_ack_n, // acknowledge, active low
   input wire prog_machine_wait, // stall request
   input wire [7:0] chip_sel_n_r, // chip selects
   input wire addr_latch_en, // latch enable
   input wire [7:0] lane_write_en_n, // write lanes
   input wire [7:0] sdram_data_mask, // sdram masks
   input wire [7:0] prog_machine_byte_sel_n, // byte selects
   input wire sdram_addr10_cmd, // address 10
   input wire [5:0] prog_gp_line, // gp lines
   input wire sdram_row_strobe_n, // row strobe
   input wire sdram_col_strobe_n, // column strobe
   input wire mem_output_en_n, // output enable
   input wire sdram_addr_mux_ctrl // address mux
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // lanes of the chip-select machine, either direction
   wire cs_lane = (lane_write_en_n != 8'hff) || !mem_output_en_n;
   a_cs_one_hot: assert property ($countones(~chip_sel_n_r) <= 1)
      else $error("two chip selects active");
   a_one_machine: assert property ((lane_write_en_n != 8'hff) + (sdram_data_mask != 8'hff)
      + (prog_machine_byte_sel_n != 8'hff) <= 1) else $error("two machines drive lanes");
   a_idle_negated: assert property (!busy |-> chip_sel_n_r == 8'hff && !cs_lane)
      else $error("strobes active while idle");
   a_read_no_write: assert property (!mem_output_en_n |-> lane_write_en_n == 8'hff)
      else $error("output enable with write lanes");
   a_ack_ends: assert property (cs_lane && !chipsel_transfer_ack_n |-> ##[1:3] done)
      else $error("acknowledge did not end access");
   a_done_pulse: assert property (done |-> !busy && $past(busy) ##1 !done)
      else $error("done not a single pulse after busy");
   a_sd_sequence: assert property ($fell(sdram_row_strobe_n) |=> sdram_row_strobe_n
      ##1 !sdram_col_strobe_n ##1 sdram_col_strobe_n) else $error("sdram strobe order");
   a_col_a10: assert property (!sdram_col_strobe_n |-> sdram_addr10_cmd)
      else $error("address 10 low in column phase");
   a_ale_start: assert property ($rose(busy) |-> addr_latch_en == ext_master)
      else $error("latch enable wrong at start");
   a_mux_mode: assert property (sdram_addr_mux_ctrl |-> ext_master)
      else $error("mux control outside external master");
   a_wait_stall: assert property ((busy && prog_machine_wait)[*2]
      |-> $stable(prog_gp_line)) else $error("gp lines moved during wait");
   c_sd_col: cover property (!sdram_col_strobe_n && sdram_addr_mux_ctrl);
   c_ack_end: cover property (cs_lane && !chipsel_transfer_ack_n ##1 done);
   c_wait: cover property (busy && prog_machine_wait);
endmodule

bind memctl_pins memctl_pins_chk chk_u (.clk(clk), .rst(rst), .busy(busy), .done(done),
   .ext_master(ext_master), .chipsel_transfer_ack_n(chipsel_transfer_ack_n),
   .prog_machine_wait(prog_machine_wait), .chip_sel_n_r(chip_sel_n_r),
   .addr_latch_en(addr_latch_en), .lane_write_en_n(lane_write_en_n),
   .sdram_data_mask(sdram_data_mask), .prog_machine_byte_sel_n(prog_machine_byte_sel_n),
   .sdram_addr10_cmd(sdram_addr10_cmd), .prog_gp_line(prog_gp_line),
   .sdram_row_strobe_n(sdram_row_strobe_n), .sdram_col_strobe_n(sdram_col_strobe_n),
   .mem_output_en_n(mem_output_en_n), .sdram_addr_mux_ctrl(sdram_addr_mux_ctrl));

// file: tb/mem_dev_model.sv
`timescale 1ns/10ps
// ==========================================
// far side: acknowledging memories and a slow programmable device
module mem_dev_model (
   input wire clk, // system clock
   input wire [7:0] chip_sel_n_r, // chip selects from the controller
   input wire [3:0] ack_dly, // cycles before acknowledge
   input wire [3:0] wait_cyc, // cycles the wait line stays high
   output wire chipsel_transfer_ack_n, // acknowledge, pulled up when idle
   output wire prog_machine_wait // high while not ready
);
   reg [3:0] sel_cnt_r = 4'h0;
   // age of the current selection, restarts when all deselected
   always @(posedge clk) begin
      if (&chip_sel_n_r)
         sel_cnt_r <= 4'h0;
      else if (sel_cnt_r != 4'hf)
         sel_cnt_r <= sel_cnt_r + 4'h1;
   end
   // only chip-select machine devices answer; the pull-up holds the line high otherwise
   assign chipsel_transfer_ack_n = !((!chip_sel_n_r[0] || !chip_sel_n_r[3])
      && sel_cnt_r >= ack_dly);
   assign prog_machine_wait = !chip_sel_n_r[2] && sel_cnt_r < wait_cyc;
endmodule

// file: tb/memctl_pins_tb.sv
`timescale 1ns/10ps
`include "memctl_pins_defines.vh"
// ==========================================
// self-checking bench for the memory controller pins
module memctl_pins_tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg req = 1'b0;
   reg [2:0] r_cs = 3'h0;
   reg r_wr = 1'b0;
   reg [2:0] r_lsb = 3'h0;
   reg [1:0] r_burst = 2'h0;
   reg r_a10 = 1'b0;
   reg [1:0] r_size = 2'h0;
   reg r_par = 1'b0;
   reg ext_m = 1'b0;
   reg bmode = 1'b0;
   reg [3:0] ack_dly = 4'h0;
   reg [3:0] wait_cyc = 4'h0;
   wire ack_n, wait_w, busy, done, ale, a10, we_n, ras_n, cas_n, oe_n, par_n, bufa, bufb, mux;
   wire [7:0] cs_n, lwe_n, mask, bsel_n;
   wire [1:0] burst;
   wire [5:0] gp;
   integer num_errors = 0;
   integer comparisons = 0;
   integer lat, lat0;
   reg [7:0] c_cs, c_lwe, c_mask, c_bsel;
   reg [5:0] c_gp;
   reg [1:0] c_burst;
   reg c_oe, c_par, c_a10r, c_a10c, c_we, c_bufa, c_bufb, c_ras, c_ale, c_mux;
   // free-running clock
   initial begin
      forever #5 clk = ~clk;
   end
   memctl_pins #(.PROG_LEN(4)) dut_u (.clk(clk), .rst(rst), .req(req), .req_cs(r_cs),
      .req_write(r_wr), .req_addr_lsb(r_lsb), .req_addr_burst(r_burst), .sdram_addr10(r_a10),
      .req_size(r_size), .req_parity(r_par), .ext_master(ext_m),
      .cs_machine({8'h00, 2'h3, `MACH_PROG, `MACH_SDRAM, `MACH_CS}),
      .cs_port_width({8'h00, `PORT_8, `PORT_32, `PORT_64, `PORT_32}),
      .buffer_ctrl_config_field(bmode), .prog_gp_pattern({6'h08, 6'h04, 6'h02, 6'h01}),
      .chipsel_transfer_ack_n(ack_n), .prog_machine_wait(wait_w), .busy(busy), .done(done),
      .chip_sel_n_r(cs_n), .buffer_ctrl_a(bufa), .buffer_ctrl_b(bufb), .burst_addr_bits(burst),
      .addr_latch_en(ale), .lane_write_en_n(lwe_n), .sdram_data_mask(mask),
      .prog_machine_byte_sel_n(bsel_n), .sdram_addr10_cmd(a10), .prog_gp_line(gp),
      .sdram_write_en_n(we_n), .sdram_row_strobe_n(ras_n), .sdram_col_strobe_n(cas_n),
      .mem_output_en_n(oe_n), .parity_byte_sel_n(par_n), .sdram_addr_mux_ctrl(mux));
   mem_dev_model dev_u (.clk(clk), .chip_sel_n_r(cs_n), .ack_dly(ack_dly),
      .wait_cyc(wait_cyc), .chipsel_transfer_ack_n(ack_n), .prog_machine_wait(wait_w));
   // ==========================================
   // shared tasks
   task end_sim;
      begin
         $display("compares %0d mismatches %0d", comparisons, num_errors);
         if (num_errors == 0 && comparisons > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task check(input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // one access; snapshots the first cycle and the column phase, counts cycles to done
   task access(input [2:0] cs, input wr, input [2:0] lsb, input [1:0] sz);
      begin
         {r_cs, r_wr, r_lsb, r_size} = {cs, wr, lsb, sz};
         req = 1'b1;
         @(negedge clk);
         req = 1'b0;
         // column-phase we, a10 and mux start unknown and the mask starts at zero, so a missing column phase fails the we, a10 and mux checks
         {c_mask, c_we, c_a10c, c_mux} = {8'h00, 1'bx, 1'bx, 1'bx};
         {c_cs, c_lwe, c_oe, c_par, c_burst, c_bufa, c_bufb, c_bsel, c_gp, c_a10r, c_ras, c_ale} =
            {cs_n, lwe_n, oe_n, par_n, burst, bufa, bufb, bsel_n, gp, a10, ras_n, ale};
         lat = 0;
         while (done !== 1'b1 && lat < 40) begin
            if (cas_n === 1'b0)
               {c_mask, c_we, c_a10c, c_mux} = {mask, we_n, a10, mux};
            @(negedge clk);
            lat = lat + 1;
         end
         if (lat == 40) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, done, 1'b1);
            end_sim;
         end
      end
   endtask
   // ==========================================
   // scenarios
   task t_cs_write;
      begin
         {bmode, r_burst, r_par, ack_dly} = {1'b0, 2'h2, 1'b1, 4'h0};
         access(3'h0, 1'b1, 3'h0, `SIZE_4);
         check(c_cs, 8'hfe);
         check(c_lwe, 8'hf0);
         check({7'h0, c_oe}, 8'h01);
         check({7'h0, c_par}, 8'h00);
         check({6'h0, c_burst}, 8'h02);
         check({6'h0, c_bufa, c_bufb}, 8'h02);
         check(c_bsel, 8'hff);
         check({7'h0, c_ale}, 8'h00);
         r_par = 1'b0;
         access(3'h3, 1'b1, 3'h5, `SIZE_1);
         check(c_cs, 8'hf7);
         check(c_lwe, 8'hfe);
         check({7'h0, c_par}, 8'h01);
         $display("test cs_write finished");
      end
   endtask
   task t_cs_read_ack;
      begin
         {bmode, ack_dly} = {1'b1, 4'h6};
         access(3'h0, 1'b0, 3'h2, `SIZE_2);
         check({7'h0, c_oe}, 8'h00);
         check(c_lwe, 8'hff);
         check({6'h0, c_bufa, c_bufb}, 8'h01);
         check({7'h0, lat >= 6 && lat <= 9}, 8'h01);
         $display("test cs_read_ack finished");
      end
   endtask
   task t_sdram;
      integer w;
      begin
         for (w = 0; w < 2; w = w + 1) begin
            // second pass: write, full 8-byte size, external master mode
            {r_a10, ext_m} = {w[0], w[0]};
            access(3'h1, w[0], w[0] ? 3'h0 : 3'h4, w[0] ? `SIZE_8 : `SIZE_4);
            check({7'h0, c_ras}, 8'h00);
            check({7'h0, c_a10r}, {7'h0, w[0]});
            check({7'h0, c_a10c}, 8'h01);
            check(c_mask, w[0] ? 8'h00 : 8'h0f);
            check({7'h0, c_ale}, {7'h0, w[0]});
            check({7'h0, c_mux}, {7'h0, w[0]});
            check({7'h0, c_we}, {7'h0, ~w[0]});
            check(lat[7:0], 8'h05);
            check(c_lwe, 8'hff);
         end
         ext_m = 1'b0;
         $display("test sdram finished");
      end
   endtask
   task t_prog;
      begin
         wait_cyc = 4'h0;
         access(3'h2, 1'b1, 3'h2, `SIZE_2);
         check(c_bsel, 8'hf3);
         check({2'h0, c_gp}, 8'h01);
         check(lat[7:0], 8'h05);
         lat0 = lat;
         wait_cyc = 4'h3;
         access(3'h2, 1'b0, 3'h2, `SIZE_2);
         check(lat[7:0], lat0[7:0] + 8'h03);
         $display("test prog finished");
      end
   endtask
   // reset, then every scenario in turn
   initial begin
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_cs_write;
      t_cs_read_ack;
      t_sdram;
      t_prog;
      end_sim;
   end
endmodule
